// File: startup_sequencer.sv
// Boot-voltage start-up and voltage-code hand-over sequencer with APB registers
`timescale 1ns/1ps
`default_nettype none

module startup_sequencer (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire seq_pkg::apb_req_t apb_req,
  output var  seq_pkg::apb_rsp_t apb_rsp,
  input  wire logic [11:0]      run_ss_mv,
  input  wire logic [10:0]      vout_mv,
  input  wire logic [3:0]       ss_pullup_ua,
  input  wire logic             voltage_code_bit0,
  input  wire logic             voltage_code_bit1,
  input  wire logic             voltage_code_bit2,
  input  wire logic             voltage_code_bit3,
  input  wire logic             voltage_code_bit4,
  input  wire logic             voltage_code_bit5,
  input  wire logic             chipset_power_good_in,
  output var  seq_pkg::seq_out_t seq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0]        sync1;
    logic [6:0]        sync2;
    logic [6:0]        sync3;
    logic [6:0]        pins;
    seq_pkg::phase_t   phase;
    logic [3:0]        cnt;
    logic [10:0]       boot_mv;
    logic [7:0]        sw_period;
    seq_pkg::apb_rsp_t rsp;
    seq_pkg::seq_out_t out;
  } seq_state_t;

  seq_state_t q;
  seq_state_t d;

  logic        sw_tick;
  logic [5:0]  code;
  logic        chip_pg;
  logic [10:0] vid_mv;
  logic [10:0] target_mv;
  logic [10:0] err_mv;
  logic        in_window;
  logic [17:0] ramp_prod;
  logic [17:0] ramp_quot;
  logic [6:0]  ramp_ilim;
  logic        setup;
  logic        access;

  // ----------------------------------------------------------------
  // Switching clock
  // ----------------------------------------------------------------
  switch_tick_gen u_tick (
    .mclk   (mclk),
    .reset  (reset),
    .clk_en (clk_en),
    .run    (q.out.switching_enable),
    .period (q.sw_period),
    .tick   (sw_tick)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Filtered pins: code in low six bits, chipset power good on top
  assign code    = q.pins[5:0];
  assign chip_pg = q.pins[6];

  // Code to setpoint, falling one step per count
  assign vid_mv = seq_pkg::VID_TOP_MV - {1'b0, code, 4'h0};

  // Window follows the live target so power good stays meaningful after hand-over
  assign target_mv = q.out.code_mode_select ? q.out.code_setpoint : q.boot_mv;
  assign err_mv    = (vout_mv > target_mv) ? vout_mv - target_mv : target_mv - vout_mv;
  assign in_window = ({4'h0, err_mv} * seq_pkg::PG_WINDOW_DIV) <= {4'h0, target_mv};

  // Linear current-limit ramp; divider is by a constant so it folds small
  assign ramp_prod = {6'h00, run_ss_mv - seq_pkg::START_MV} * seq_pkg::ILIM_SPAN_MV;
  assign ramp_quot = ramp_prod / seq_pkg::RAMP_SPAN_MV;
  assign ramp_ilim = seq_pkg::ILIM_MIN_MV + ramp_quot[6:0];

  assign setup  = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable && q.rsp.pready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;

    // Three-stage pin filter; a bit changes once stages two and three agree
    d.sync1 = {chipset_power_good_in, voltage_code_bit5, voltage_code_bit4,
               voltage_code_bit3, voltage_code_bit2, voltage_code_bit1, voltage_code_bit0};
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.pins  = ((q.sync2 ~^ q.sync3) & q.sync3) | ((q.sync2 ^ q.sync3) & q.pins);

    // Sequencing by run level, then by phase
    if (run_ss_mv < seq_pkg::SHUTDOWN_MV) begin
      d.phase = seq_pkg::PH_SHUTDOWN;
      d.cnt   = 4'h0;
      d.out.code_mode_select = 1'b0;
    end else if (run_ss_mv < seq_pkg::START_MV) begin
      d.phase = seq_pkg::PH_IDLE;
      d.cnt   = 4'h0;
      d.out.code_mode_select = 1'b0;
    end else begin
      unique case (q.phase)
        seq_pkg::PH_SHUTDOWN, seq_pkg::PH_IDLE: begin
          d.phase = seq_pkg::PH_RAMP;
        end
        seq_pkg::PH_RAMP: begin
          if (run_ss_mv >= seq_pkg::FULL_MV) begin
            d.phase = seq_pkg::PH_BOOT;
          end
        end
        seq_pkg::PH_BOOT: begin
          if (!q.out.composite_power_good) begin
            d.cnt = 4'h0;
          end else if (sw_tick) begin
            if (q.cnt == seq_pkg::BOOT_CYCLES - 4'h1) begin
              d.phase = seq_pkg::PH_VID;
              d.out.code_mode_select = 1'b1;
            end else begin
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        seq_pkg::PH_VID: begin
          d.phase = seq_pkg::PH_VID;
        end
      endcase
    end

    // Outputs derived from the next phase; latch-off from the pull-up current alone
    d.out.shutdown         = (d.phase == seq_pkg::PH_SHUTDOWN);
    d.out.switching_enable = (d.phase == seq_pkg::PH_RAMP) || (d.phase == seq_pkg::PH_BOOT)
                           || (d.phase == seq_pkg::PH_VID);
    d.out.composite_power_good = d.out.switching_enable && (q.phase != seq_pkg::PH_RAMP)
                               && in_window && chip_pg;
    d.out.latchoff_enable  = (ss_pullup_ua <= seq_pkg::PULLUP_DEFEAT_UA);

    // Target and leg selection; code takes over only in the final phase
    if (d.phase == seq_pkg::PH_VID) begin
      d.out.code_setpoint     = vid_mv;
      d.out.feedback_leg_code = code;
    end else if (d.out.switching_enable) begin
      d.out.code_setpoint     = q.boot_mv;
      d.out.feedback_leg_code = 6'h00;
    end else begin
      d.out.code_setpoint     = 11'h000;
      d.out.feedback_leg_code = 6'h00;
    end

    // Current limit: ramp while below full level, ceiling above it
    if (!d.out.switching_enable) begin
      d.out.current_limit_mv = 7'h00;
    end else if (run_ss_mv >= seq_pkg::FULL_MV) begin
      d.out.current_limit_mv = seq_pkg::ILIM_MAX_MV;
    end else begin
      d.out.current_limit_mv = ramp_ilim;
    end

    // APB slave: answer one cycle after setup, data latched then
    d.rsp.pready  = 1'b0;
    d.rsp.pslverr = 1'b0;
    if (setup) begin
      d.rsp.pready = 1'b1;
      d.rsp.prdata = 32'h0000_0000;
      unique case (apb_req.paddr)
        seq_pkg::REG_BOOT_MV:   d.rsp.prdata[10:0] = q.boot_mv;
        seq_pkg::REG_SW_PERIOD: d.rsp.prdata[7:0]  = q.sw_period;
        seq_pkg::REG_STATUS: begin
          d.rsp.prdata[2:0]                  = q.phase;
          d.rsp.prdata[seq_pkg::ST_PG_BIT]    = q.out.composite_power_good;
          d.rsp.prdata[seq_pkg::ST_MODE_BIT]  = q.out.code_mode_select;
          d.rsp.prdata[seq_pkg::ST_LATCH_BIT] = q.out.latchoff_enable;
          d.rsp.prdata[seq_pkg::ST_CODE_LSB +: 6] = code;
          d.rsp.prdata[seq_pkg::ST_CHIP_BIT]  = chip_pg;
        end
        seq_pkg::REG_LEVELS: begin
          d.rsp.prdata[10:0]                     = q.out.code_setpoint;
          d.rsp.prdata[seq_pkg::LV_ILIM_LSB +: 7] = q.out.current_limit_mv;
        end
        default: d.rsp.pslverr = 1'b1;
      endcase
    end
    if (access && apb_req.pwrite) begin
      if (apb_req.paddr == seq_pkg::REG_BOOT_MV) begin
        d.boot_mv = apb_req.pwdata[10:0];
      end
      // A zero period would stretch the tick to every 256 cycles; keep the old value instead
      if (apb_req.paddr == seq_pkg::REG_SW_PERIOD && apb_req.pwdata[7:0] != 8'h00) begin
        d.sw_period = apb_req.pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      q           <= '0;
      q.boot_mv   <= seq_pkg::BOOT_MV_RST;
      q.sw_period <= seq_pkg::SW_PERIOD_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign apb_rsp = q.rsp;
  assign seq_out = q.out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence boot_hold_s;
    q.phase == seq_pkg::PH_BOOT && q.cnt == seq_pkg::BOOT_CYCLES - 4'h1;
  endsequence

  sequence mode_on_s;
    q.out.code_mode_select && q.out.code_setpoint == vid_mv;
  endsequence

  chk_code_setpoint: assert property (
    q.out.code_mode_select |->
      q.out.code_setpoint == seq_pkg::VID_TOP_MV - {1'b0, q.out.feedback_leg_code, 4'h0}
      && q.out.code_setpoint >= seq_pkg::VID_BOTTOM_MV)
    else $error("code setpoint out of step with leg code");

  chk_shutdown_quiet: assert property (
    (clk_en && run_ss_mv < seq_pkg::SHUTDOWN_MV) |=>
      q.out.shutdown && !q.out.switching_enable && !q.out.code_mode_select)
    else $error("activity during shutdown");

  chk_idle_start: assert property (
    (clk_en && run_ss_mv < seq_pkg::START_MV) |=> !q.out.switching_enable)
    else $error("switching below start level");

  chk_ilim_ceiling: assert property (
    (clk_en && run_ss_mv >= seq_pkg::FULL_MV) |=>
      q.out.current_limit_mv == seq_pkg::ILIM_MAX_MV)
    else $error("current limit not at ceiling after ramp");

  chk_latch_defeat: assert property (
    (clk_en && ss_pullup_ua > seq_pkg::PULLUP_DEFEAT_UA) |=> !q.out.latchoff_enable)
    else $error("latch-off still enabled under pull-up");

  chk_boot_target: assert property (
    (q.phase == seq_pkg::PH_BOOT) |-> q.out.code_setpoint == q.boot_mv)
    else $error("boot target not applied");

  chk_pg_and: assert property (
    ($past(clk_en) && q.out.composite_power_good) |-> $past(chip_pg) && $past(in_window))
    else $error("power good rose without chipset power good");

  chk_mode_delay: assert property (
    $rose(q.out.code_mode_select) |-> $past(q.phase) == seq_pkg::PH_BOOT
      && $past(q.cnt) == seq_pkg::BOOT_CYCLES - 4'h1 && $past(q.out.composite_power_good))
    else $error("mode select without full boot delay");

  chk_mode_entry: assert property (
    (boot_hold_s ##0 (clk_en && sw_tick && q.out.composite_power_good
      && run_ss_mv >= seq_pkg::START_MV)) |=> mode_on_s)
    else $error("hand-over to code voltage missed");

  chk_count_clear: assert property (
    (clk_en && q.phase == seq_pkg::PH_BOOT && !q.out.composite_power_good) |=> q.cnt == 4'h0)
    else $error("boot count not cleared on power good loss");

endmodule : startup_sequencer

`default_nettype wire

// File: seq_pkg.sv
// Shared constants, types and register map of the start-up sequencer
package seq_pkg;

  // ----------------------------------------------------------------
  // Clock and switching period
  // ----------------------------------------------------------------
  localparam int unsigned MCLK_HZ      = 25_000_000;
  localparam logic [7:0]  SW_PERIOD_RST = 8'h53;    // About 300 kHz at mclk

  // ----------------------------------------------------------------
  // Run/soft-start thresholds, millivolts
  // ----------------------------------------------------------------
  localparam logic [11:0] SHUTDOWN_MV  = 12'h3E8;   // 1.0 V
  localparam logic [11:0] START_MV     = 12'h5DC;   // 1.5 V
  localparam logic [11:0] FULL_MV      = 12'hBB8;   // 3.0 V
  localparam logic [17:0] RAMP_SPAN_MV = 18'h005DC; // 3.0 V - 1.5 V

  // ----------------------------------------------------------------
  // Current limit across the sense resistor, millivolts
  // ----------------------------------------------------------------
  localparam logic [6:0]  ILIM_MIN_MV  = 7'h19;     // 25 mV
  localparam logic [6:0]  ILIM_MAX_MV  = 7'h48;     // 72 mV
  localparam logic [17:0] ILIM_SPAN_MV = 18'h0002F; // 72 mV - 25 mV
  localparam logic [3:0]  PULLUP_DEFEAT_UA = 4'h5;  // Latch-off defeat level

  // ----------------------------------------------------------------
  // Setpoints
  // ----------------------------------------------------------------
  localparam logic [10:0] VID_TOP_MV    = 11'h6AC;  // 1.708 V, code 0
  localparam logic [10:0] VID_BOTTOM_MV = 11'h2BC;  // 0.700 V, code 63
  localparam int unsigned VID_STEP_SHIFT = 4;       // 16 mV per step
  localparam logic [10:0] BOOT_MV_RST   = 11'h4B0;  // 1.2 V
  localparam logic [14:0] PG_WINDOW_DIV = 15'h000A; // Plus or minus 10 %
  localparam logic [3:0]  BOOT_CYCLES   = 4'hF;     // Switching periods

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_BOOT_MV   = 8'h00;
  localparam logic [7:0] REG_SW_PERIOD = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_LEVELS    = 8'h0C;
  localparam int unsigned ST_PG_BIT    = 3;
  localparam int unsigned ST_MODE_BIT  = 4;
  localparam int unsigned ST_LATCH_BIT = 5;
  localparam int unsigned ST_CODE_LSB  = 6;
  localparam int unsigned ST_CHIP_BIT  = 12;
  localparam int unsigned LV_ILIM_LSB  = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {PH_SHUTDOWN, PH_IDLE, PH_RAMP, PH_BOOT, PH_VID} phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic        switching_enable;
    logic        shutdown;
    logic        composite_power_good;
    logic        code_mode_select;
    logic [10:0] code_setpoint;
    logic [5:0]  feedback_leg_code;
    logic [6:0]  current_limit_mv;
    logic        latchoff_enable;
  } seq_out_t;

endpackage : seq_pkg

// File: switch_tick_gen.sv
// Switching-period tick generator driven by a programmable period
`timescale 1ns/1ps
`default_nettype none

module switch_tick_gen (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       run,
  input  wire logic [7:0] period,
  output var  logic       tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } tick_state_t;

  tick_state_t q;
  tick_state_t d;

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  // Held at zero while idle so the first period after start is whole
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (!run) begin
      d.cnt = 8'h00;
    end else if (q.cnt >= period - 8'h01) begin
      d.cnt  = 8'h00;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  // Registered state
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule : switch_tick_gen

`default_nettype wire

// File: code_source.sv
// Model of the processor code pins and the chipset power-good driver
`timescale 1ns/1ps
`default_nettype none

module code_source (
  input  wire logic       mclk,
  input  wire logic [5:0] code,
  input  wire logic       chip_ok,
  output var  logic [5:0] code_pins,
  output var  logic       chip_good
);
  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  // Lines are always driven hard; the pins have no default of their own
  always_ff @(posedge mclk) begin
    code_pins <= code;
    chip_good <= chip_ok;  // Chipset side of the power-good AND
  end
endmodule : code_source
`default_nettype wire

// File: vid_boot_startup_sequencer_test.sv
// Self-checking bench of the start-up sequencer
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end

module vid_boot_startup_sequencer_test;
  typedef struct packed {
    logic [11:0] run;
    logic        shut;
    logic        sw;
    logic [6:0]  ilim;
    logic [10:0] sp;
  } row_t;

  // Run level sweep, ascending so the phases only move forward
  localparam row_t ROWS [8] = '{
    '{12'h1F4, 1'b1, 1'b0, 7'h00, 11'h000}, '{12'h3E7, 1'b1, 1'b0, 7'h00, 11'h000},
    '{12'h3E8, 1'b0, 1'b0, 7'h00, 11'h000}, '{12'h5DB, 1'b0, 1'b0, 7'h00, 11'h000},
    '{12'h5DC, 1'b0, 1'b1, 7'h19, 11'h4B0}, '{12'h8CA, 1'b0, 1'b1, 7'h30, 11'h4B0},
    '{12'hBB7, 1'b0, 1'b1, 7'h47, 11'h4B0}, '{12'hBB8, 1'b0, 1'b1, 7'h48, 11'h4B0}};
  localparam logic [5:0] CODES [6] = '{6'h00, 6'h01, 6'h1F, 6'h20, 6'h3E, 6'h3F};

  logic               mclk = 1'b0;
  logic               reset = 1'b1;
  logic               clk_en;
  seq_pkg::apb_req_t  apb_req;
  seq_pkg::apb_rsp_t  apb_rsp;
  logic [11:0]        run_ss_mv;
  logic [10:0]        vout_mv;
  logic [3:0]         ss_pullup_ua;
  logic [5:0]         code;
  logic               chip_ok;
  logic [5:0]         code_pins;
  logic               chip_good;
  seq_pkg::seq_out_t  seq_out;
  logic [31:0]        rdata;
  logic               rerr;
  logic [10:0]        exp_sp;
  int                 mismatches = 0;
  int                 n_checks = 0;
  int                 k;

  // ------------------------------------------------------------------
  // Clock, design and far side
  // ------------------------------------------------------------------
  always #20 mclk = ~mclk;

  startup_sequencer startup_sequencer_inst (
    .mclk, .reset, .clk_en, .apb_req, .apb_rsp, .run_ss_mv, .vout_mv, .ss_pullup_ua,
    .voltage_code_bit0(code_pins[0]), .voltage_code_bit1(code_pins[1]),
    .voltage_code_bit2(code_pins[2]), .voltage_code_bit3(code_pins[3]),
    .voltage_code_bit4(code_pins[4]), .voltage_code_bit5(code_pins[5]),
    .chipset_power_good_in(chip_good), .seq_out);

  code_source code_source_inst (.mclk, .code, .chip_ok, .code_pins, .chip_good);

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic conclude;
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // One APB transfer; request held until pready is seen, then one idle edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    w = 0;
    do begin
      @(posedge mclk);
      w++;
    end while (apb_rsp.pready !== 1'b1 && w < 20);
    if (w >= 20) begin
      mismatches++;
      conclude();
    end else begin
      rdata = apb_rsp.prdata;
      rerr = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge mclk);
    end
  endtask : apb

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    clk_en = 1'b1;
    apb_req = '0;
    run_ss_mv = 12'h000;
    vout_mv = 11'h000;
    ss_pullup_ua = 4'h0;
    code = 6'h00;
    chip_ok = 1'b0;
    cyc(4);
    `CHK("outputs in reset", seq_pkg::seq_out_t'(0), seq_out)
    cyc(1);
    reset <= 1'b0;
    cyc(1);
    // Register defaults, bad address, read-back of a short period
    apb(1'b0, seq_pkg::REG_BOOT_MV, 32'h0);
    `CHK("boot reg", 32'h000004B0, rdata)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, rerr)
    apb(1'b1, seq_pkg::REG_SW_PERIOD, 32'h4);
    apb(1'b1, seq_pkg::REG_SW_PERIOD, 32'h0);
    apb(1'b0, seq_pkg::REG_SW_PERIOD, 32'h0);
    `CHK("period reg", 32'h00000004, rdata)
    // Run level sweep through shutdown, idle, ramp and boot
    for (int i = 0; i < 8; i++) begin
      run_ss_mv <= ROWS[i].run;
      cyc(3);
      `CHK("shutdown", ROWS[i].shut, seq_out.shutdown)
      `CHK("switching", ROWS[i].sw, seq_out.switching_enable)
      `CHK("current limit", ROWS[i].ilim, seq_out.current_limit_mv)
      `CHK("boot setpoint", ROWS[i].sp, seq_out.code_setpoint)
    end
    // Latch-off defeat needs strictly more than five microamps
    ss_pullup_ua <= 4'h5;
    cyc(3);
    `CHK("latch armed", 1'b1, seq_out.latchoff_enable)
    ss_pullup_ua <= 4'h6;
    cyc(3);
    `CHK("latch defeated", 1'b0, seq_out.latchoff_enable)
    // Power good needs both halves; code is ignored before the hand-over
    code <= 6'h0D;
    vout_mv <= 11'h4B0;
    cyc(8);
    `CHK("pg chipset low", 1'b0, seq_out.composite_power_good)
    `CHK("code ignored", 11'h4B0, seq_out.code_setpoint)
    chip_ok <= 1'b1;
    vout_mv <= 11'h3E8;
    cyc(8);
    `CHK("pg out of window", 1'b0, seq_out.composite_power_good)
    vout_mv <= 11'h44C;
    cyc(30);
    `CHK("pg in window", 1'b1, seq_out.composite_power_good)
    `CHK("mode early", 1'b0, seq_out.code_mode_select)
    // Drop power good mid-count; the count must start over
    chip_ok <= 1'b0;
    cyc(8);
    `CHK("pg dropped", 1'b0, seq_out.composite_power_good)
    chip_ok <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (seq_out.code_mode_select !== 1'b1 && k < 200);
    // Pin path 6 edges, then 15 ticks of 4 with unknown tick phase:
    // one tick more or less falls outside this window
    `CHK("boot delay span", 1'b1, k >= 64 && k <= 67)
    `CHK("hand-over value", 11'h5DC, seq_out.code_setpoint)
    // Code sweep; partner flop, three-stage filter and output register need 6 edges
    foreach (CODES[i]) begin
      code <= CODES[i];
      exp_sp = seq_pkg::VID_TOP_MV - 11'({CODES[i], 4'h0});
      vout_mv <= exp_sp;
      cyc(8);
      `CHK("code setpoint", exp_sp, seq_out.code_setpoint)
      `CHK("feedback leg", CODES[i], seq_out.feedback_leg_code)
      `CHK("mode held", 1'b1, seq_out.code_mode_select)
    end
    apb(1'b1, seq_pkg::REG_STATUS, 32'hFFFFFFFF);
    apb(1'b0, seq_pkg::REG_STATUS, 32'h0);
    `CHK("status phase", 3'h4, rdata[2:0])
    `CHK("status mode", 1'b1, rdata[seq_pkg::ST_MODE_BIT])
    apb(1'b0, seq_pkg::REG_LEVELS, 32'h0);
    `CHK("levels setpoint", 11'h2BC, rdata[10:0])
    // Shutdown clears the hand-over at once
    run_ss_mv <= 12'h1F4;
    cyc(3);
    `CHK("shutdown again", 1'b1, seq_out.shutdown)
    `CHK("mode cleared", 1'b0, seq_out.code_mode_select)
    `CHK("no switching", 1'b0, seq_out.switching_enable)
    // Clock enable low freezes everything even as the run level jumps
    clk_en <= 1'b0;
    run_ss_mv <= 12'hBB8;
    cyc(4);
    `CHK("frozen shutdown", 1'b1, seq_out.shutdown)
    `CHK("frozen switching", 1'b0, seq_out.switching_enable)
    clk_en <= 1'b1;
    cyc(3);
    `CHK("restart switching", 1'b1, seq_out.switching_enable)
    `CHK("restart ceiling", 7'h48, seq_out.current_limit_mv)
    `CHK("restart mode clear", 1'b0, seq_out.code_mode_select)
    if (k >= 200) begin
      mismatches++;
    end
    conclude();
  end
endmodule : vid_boot_startup_sequencer_test
`default_nettype wire
